//--- design/sfs_pkg.sv
// shared constants and carrier types of the sensor frame serial slave
// assumes a 20 MHz system clock and a select-bounded serial link clocked by the master
package sfs_pkg;

    // frame geometry
    localparam int          FRAME_BITS   = 64;
    localparam int          FRAME_BYTES  = 8;
    localparam int          CRC_BYTES    = 7;
    localparam int          CNT_W        = 7;
    localparam logic [6:0]  CNT_FRAME    = 7'h40;
    localparam logic [6:0]  CNT_MAX      = 7'h7F;
    localparam logic [6:0]  CNT_FIRST    = 7'h01;

    // checksum: preset, msb-first generator 2F; it reproduces the 0xC2 lookup table
    localparam logic [7:0]  CRC_INIT     = 8'hFF;
    localparam logic [7:0]  CRC_POLY     = 8'h2F;

    // frame type tag of every non-regular frame
    localparam logic [1:0]  MARKER_OTHER = 2'h3;

    // reset values
    localparam logic [63:0] TX_RESET_FRAME = 64'h0000000000000000;
    localparam logic [7:0]  ERR_RESET      = 8'h00;
    localparam logic [7:0]  ERR_MAX        = 8'hFF;

    // timing
    localparam int          CLK_HZ          = 20000000;
    localparam int          BIT_RATE_BPS    = 2000000;
    localparam int          BIT_TIME_NS     = 1000000000 / BIT_RATE_BPS;
    localparam int          FRAME_RATE_MAX  = 1000;
    localparam int          FRAME_PERIOD_US = 1000000 / FRAME_RATE_MAX;
    localparam int          FRAME_PERIOD_CYC = FRAME_PERIOD_US * (CLK_HZ / 1000000);

    // one frame, byte 0 in the top bits
    typedef struct packed {
        logic [47:0] payload;
        logic [1:0]  marker;
        logic [5:0]  code;
        logic [7:0]  crc;
    } sfs_frame_s;

    // outcome of one select-low period
    typedef struct packed {
        logic        len_err;
        logic        crc_err;
        logic        regular;
        logic        sync_pulse;
        logic        rate_fast;
    } sfs_stat_s;

    // link-domain words handed to the system domain
    typedef struct packed {
        logic [63:0] bits;
        logic [6:0]  count;
    } sfs_link_s;

endpackage

//--- design/sfs_sync2.sv
// two-stage synchroniser for levels entering the system clock domain
// assumes multi-bit inputs are quasi-static while they are sampled
`timescale 1ns/100ps
module sfs_sync2 #(
    parameter int             W       = 1,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    input  wire logic         clk,    // system clock
    input  wire logic         rst,    // synchronous reset, high
    input  wire logic         ce,     // clock enable
    input  wire logic [W-1:0] d,      // asynchronous input
    output logic      [W-1:0] q       // synchronised output
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= RST_VAL;
            sync_reg <= RST_VAL;
        end else if (ce) begin
            meta_reg <= d;
            sync_reg <= meta_reg;
        end
    end

    assign q = sync_reg;
endmodule

//--- design/sfs_crc8.sv
// frame checksum over a run of bytes, first byte in the top bits
// purely combinational; the caller registers the result
`timescale 1ns/100ps
module sfs_crc8
    import sfs_pkg::*;
#(
    parameter int NBYTES = CRC_BYTES
) (
    input  wire logic [8*NBYTES-1:0] data,   // bytes, first byte msb
    output logic      [7:0]          crc     // inverted final checksum
);
    logic [7:0] stage [0:NBYTES];

    assign stage[0] = CRC_INIT;

    genvar i, b;
    generate
        for (i = 0; i < NBYTES; i++) begin : g_byte
            logic [7:0] s [0:8];
            assign s[0] = stage[i] ^ data[8*(NBYTES-i)-1 -: 8];
            // one table lookup is eight msb-first shift steps
            for (b = 0; b < 8; b++) begin : g_bit
                assign s[b+1] = s[b][7] ? ({s[b][6:0], 1'b0} ^ CRC_POLY)
                                        : {s[b][6:0], 1'b0};
            end
            assign stage[i+1] = s[8];
        end
    endgenerate

    assign crc = ~stage[NBYTES];
endmodule

//--- design/sfs_slave_top.sv
// serial frame slave: link logic on the master's clock, frame checking on CLK
// assumes the master keeps SCLK quiet outside frames and holds the select
// high for many system clocks between frames
//
// Overview of operation
// - a frame lies between a select falling edge and the next rising edge.
// - bits clocked while selected are counted; not exactly 64 marks the frame bad.
// - data changes on rising clock edge, sampled on falling; clock idles low.
// - most significant bit of every byte is shifted first on both lines.
// - in pulse mode a select pulse with a quiet clock is an acquisition trigger.
// - the return data line is released whenever the select is high.
// - every frame but the all-zero reset answer carries an 8-bit checksum, generated on send, checked on receive.
// - bytes zero to seven go out in ascending order.
// - byte seven holds the checksum.
// - byte six holds the type tag and the opcode or rolling count.
// - acquisition starts only on link events; frames are passed on for programming.
// - full-duplex link at a bit rate of 2 Mbps.
// - frame handling keeps up with 1000 frames per second.
// - checksum preset to ones, bytes zero to six folded in, result inverted.
// - type tag 00, 01, 10 marks regular frames, 11 all others.
`timescale 1ns/100ps
module sfs_slave_top
    import sfs_pkg::*;
#(
    parameter int FRAME_PERIOD_CYC_P = FRAME_PERIOD_CYC
) (
    input  wire logic        CLK,          // system clock, 20 MHz
    input  wire logic        SYS_RST,      // synchronous reset, high
    input  wire logic        CE,           // clock enable for the system domain
    input  wire logic        SCLK,         // serial clock from the master
    input  wire logic        SS_N,         // select, low
    input  wire logic        MOSI,         // serial data in
    output logic             MISO_O,       // serial data out
    output logic             MISO_OE_N,    // output enable of serial data, low
    input  wire logic        PULSE_MODE,   // select pulses act as triggers
    input  wire logic [55:0] TX_PAYLOAD,   // bytes 0..6 of the next answer
    input  wire logic        TX_LOAD,      // load TX_PAYLOAD
    output logic             TX_READY,     // answer buffer may be loaded
    output sfs_frame_s       RX_FRAME,     // last good frame
    output logic             RX_VALID,     // good frame pulse
    output logic             RX_DONE,      // end of any select period
    output sfs_stat_s        RX_STATUS,    // outcome of the last period
    output logic [6:0]       RX_BITS,      // bits counted in the last period
    output logic [7:0]       ERR_COUNT,    // discarded frames, saturating
    output logic             ACQ_TRIGGER,  // start acquisition pulse
    output logic             FRAME_ACTIVE  // a frame is open
);
    localparam int GAP_W = $clog2(FRAME_PERIOD_CYC_P + 1);
    localparam logic [GAP_W-1:0] GAP_FULL = GAP_W'(FRAME_PERIOD_CYC_P);
    localparam logic [GAP_W-1:0] GAP_ONE  = GAP_W'(1);

    typedef enum logic [1:0] {ST_IDLE, ST_FRAME, ST_CHECK} sfs_state_e;

    // link domain
    logic              rx_idle_reg;
    logic [CNT_W-1:0]  bit_cnt_reg;
    logic [63:0]       rx_shift_reg;
    logic [5:0]        tx_idx_reg;
    logic              miso_reg;
    sfs_link_s         link_bundle;

    // system domain
    logic [1:0]        pins_s;
    logic              ss_n_s;
    logic              sclk_s;
    sfs_link_s         link_s;
    logic              ss_prev_reg;
    logic              ss_rise;
    logic              ss_fall;
    sfs_state_e        state_reg;
    logic              clk_seen_reg;
    logic              frame_act_reg;
    sfs_link_s         cap_reg;
    logic [63:0]       tx_frame_reg;
    logic [7:0]        tx_crc;
    logic [7:0]        rx_crc;
    logic [GAP_W-1:0]  gap_cnt_reg;
    sfs_frame_s        rx_frame_reg;
    logic              rx_valid_reg;
    logic              rx_done_reg;
    sfs_stat_s         rx_stat_reg;
    logic [6:0]        rx_bits_reg;
    logic [7:0]        err_cnt_reg;
    logic              acq_reg;
    logic              is_pulse;
    logic              len_bad;
    logic              crc_bad;
    logic              frame_ok;
    sfs_frame_s        cap_frame;

    // ---------------- link domain ----------------

    // cleared by the first sampling edge after a new selection
    always_ff @(negedge SCLK or posedge SS_N) begin
        if (SS_N) begin
            rx_idle_reg <= 1'b1;
        end else begin
            rx_idle_reg <= 1'b0;
        end
    end

    // sample on the falling edge, msb first; other slaves' traffic is ignored
    always_ff @(negedge SCLK) begin
        if (!SS_N) begin
            if (rx_idle_reg) begin
                bit_cnt_reg  <= CNT_FIRST;
                rx_shift_reg <= {63'h0, MOSI};
            end else begin
                if (bit_cnt_reg != CNT_MAX) begin
                    bit_cnt_reg <= bit_cnt_reg + CNT_FIRST;
                end
                rx_shift_reg <= {rx_shift_reg[62:0], MOSI};
            end
        end
    end

    // drive on the rising edge; byte 0 msb leaves first
    always_ff @(posedge SCLK or posedge SS_N) begin
        if (SS_N) begin
            tx_idx_reg <= 6'h00;
            miso_reg   <= 1'b0;
        end else begin
            miso_reg   <= tx_frame_reg[~tx_idx_reg];
            tx_idx_reg <= tx_idx_reg + 6'h01;
        end
    end

    assign MISO_O    = miso_reg;
    assign MISO_OE_N = SS_N;

    // words are quiet by the time the raised select is seen in the system domain
    assign link_bundle = '{bits: rx_shift_reg, count: bit_cnt_reg};

    // ---------------- crossing ----------------

    sfs_sync2 #(
        .W       (2),
        .RST_VAL (2'h2)
    ) u_sync_pins (
        .clk (CLK),
        .rst (SYS_RST),
        .ce  (CE),
        .d   ({SS_N, SCLK}),
        .q   (pins_s)
    );

    sfs_sync2 #(
        .W       ($bits(sfs_link_s)),
        .RST_VAL ('0)
    ) u_sync_link (
        .clk (CLK),
        .rst (SYS_RST),
        .ce  (CE),
        .d   (link_bundle),
        .q   (link_s)
    );

    assign ss_n_s = pins_s[1];
    assign sclk_s = pins_s[0];

    // ---------------- system domain ----------------

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            ss_prev_reg <= 1'b1;
        end else if (CE) begin
            ss_prev_reg <= ss_n_s;
        end
    end

    assign ss_fall = ss_prev_reg & ~ss_n_s;
    assign ss_rise = ~ss_prev_reg & ss_n_s;

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            state_reg <= ST_IDLE;
        end else if (CE) begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (ss_fall) begin
                        state_reg <= ST_FRAME;
                    end
                end
                ST_FRAME: begin
                    if (ss_rise) begin
                        state_reg <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // frame-open flag kept in a flop; it tracks the next state of the machine
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            frame_act_reg <= 1'b0;
        end else if (CE) begin
            if (state_reg == ST_IDLE) begin
                frame_act_reg <= ss_fall;
            end else begin
                frame_act_reg <= (state_reg == ST_FRAME) & ~ss_rise;
            end
        end
    end

    // any high clock level inside the select window means a real frame
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            clk_seen_reg <= 1'b0;
        end else if (CE) begin
            if (state_reg == ST_IDLE) begin
                clk_seen_reg <= 1'b0;
            end else if (state_reg == ST_FRAME && sclk_s) begin
                clk_seen_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            cap_reg <= '0;
        end else if (CE && state_reg == ST_FRAME && ss_rise) begin
            cap_reg <= link_s;
        end
    end

    assign cap_frame = sfs_frame_s'(cap_reg.bits);

    sfs_crc8 #(
        .NBYTES (CRC_BYTES)
    ) u_crc_rx (
        .data (cap_reg.bits[63:8]),
        .crc  (rx_crc)
    );

    assign is_pulse = ~clk_seen_reg & PULSE_MODE;
    assign len_bad  = ~is_pulse & (~clk_seen_reg | (cap_reg.count != CNT_FRAME));
    assign crc_bad  = ~is_pulse & ~len_bad & (rx_crc != cap_frame.crc);
    assign frame_ok = ~is_pulse & ~len_bad & ~crc_bad;

    // cycles since the last good frame, saturating at one frame period
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            gap_cnt_reg <= GAP_FULL;
        end else if (CE) begin
            if (state_reg == ST_CHECK && frame_ok) begin
                gap_cnt_reg <= '0;
            end else if (gap_cnt_reg != GAP_FULL) begin
                gap_cnt_reg <= gap_cnt_reg + GAP_ONE;
            end
        end
    end

    // one result per select period, two clocks after the raised select is seen
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            rx_done_reg  <= 1'b0;
            rx_valid_reg <= 1'b0;
        end else if (CE) begin
            rx_done_reg  <= (state_reg == ST_CHECK);
            rx_valid_reg <= (state_reg == ST_CHECK) & frame_ok;
        end
    end

    // acquisition starts only on a good frame or an allowed pulse
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            acq_reg <= 1'b0;
        end else if (CE) begin
            acq_reg <= (state_reg == ST_CHECK) & (frame_ok | is_pulse);
        end
    end

    // outcome of the period, held until the next one closes
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            rx_stat_reg <= '0;
            rx_bits_reg <= '0;
        end else if (CE && state_reg == ST_CHECK) begin
            rx_bits_reg            <= clk_seen_reg ? cap_reg.count : '0;
            rx_stat_reg.len_err    <= len_bad;
            rx_stat_reg.crc_err    <= crc_bad;
            rx_stat_reg.sync_pulse <= is_pulse;
            rx_stat_reg.regular    <= frame_ok & (cap_frame.marker != MARKER_OTHER);
            rx_stat_reg.rate_fast  <= frame_ok & (gap_cnt_reg != GAP_FULL);
        end
    end

    // stored frame changes only on a good frame; bad ones leave no trace
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            rx_frame_reg <= '0;
        end else if (CE && state_reg == ST_CHECK && frame_ok) begin
            rx_frame_reg <= cap_frame;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            err_cnt_reg <= ERR_RESET;
        end else if (CE && state_reg == ST_CHECK && (len_bad | crc_bad)) begin
            if (err_cnt_reg != ERR_MAX) begin
                err_cnt_reg <= err_cnt_reg + 8'h01;
            end
        end
    end

    // answer buffer: frozen while selected, checksum appended as byte seven
    sfs_crc8 #(
        .NBYTES (CRC_BYTES)
    ) u_crc_tx (
        .data (TX_PAYLOAD),
        .crc  (tx_crc)
    );

    assign TX_READY = (state_reg == ST_IDLE) & ss_n_s & ~ss_fall;

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            tx_frame_reg <= TX_RESET_FRAME;
        end else if (CE && TX_LOAD && TX_READY) begin
            tx_frame_reg <= {TX_PAYLOAD, tx_crc};
        end
    end

    assign RX_FRAME     = rx_frame_reg;
    assign RX_VALID     = rx_valid_reg;
    assign RX_DONE      = rx_done_reg;
    assign RX_STATUS    = rx_stat_reg;
    assign RX_BITS      = rx_bits_reg;
    assign ERR_COUNT    = err_cnt_reg;
    assign ACQ_TRIGGER  = acq_reg;
    assign FRAME_ACTIVE = frame_act_reg;
endmodule

//--- verif/sfs_slave_assertions.sv
// checker of the serial frame slave, bound to its top module
// assumes CE stays high while results are produced, so pulses last one cycle
`timescale 1ns/100ps
module sfs_slave_checker
    import sfs_pkg::*;
#(
    parameter int FRAME_PERIOD_CYC_P = FRAME_PERIOD_CYC
) (
    input wire logic       CLK,          // system clock
    input wire logic       SYS_RST,      // reset, high
    input wire logic       SS_N,         // select, low
    input wire logic       MISO_OE_N,    // output enable, low
    input wire logic       PULSE_MODE,   // trigger mode
    input wire logic       TX_READY,     // answer buffer free
    input wire sfs_frame_s RX_FRAME,     // last good frame
    input wire logic       RX_VALID,     // good frame pulse
    input wire logic       RX_DONE,      // period end pulse
    input wire sfs_stat_s  RX_STATUS,    // outcome
    input wire logic [6:0] RX_BITS,      // bits counted
    input wire logic [7:0] ERR_COUNT,    // discarded frames
    input wire logic       ACQ_TRIGGER,  // acquisition pulse
    input wire logic       FRAME_ACTIVE  // frame open
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);

    sequence s_result;
        ##[1:3] RX_DONE;
    endsequence
    sequence s_pulse_end;
        ##1 !RX_DONE;
    endsequence

    property p_release;
        MISO_OE_N == SS_N;
    endproperty
    property p_close;
        $fell(FRAME_ACTIVE) |-> s_result ##0 s_pulse_end;
    endproperty
    property p_count;
        RX_DONE && RX_BITS != CNT_FRAME |-> RX_STATUS.len_err || RX_STATUS.sync_pulse;
    endproperty
    property p_good;
        RX_VALID |-> RX_DONE && RX_BITS == CNT_FRAME && !RX_STATUS.len_err && !RX_STATUS.crc_err;
    endproperty
    property p_keep;
        $changed(RX_FRAME) |-> RX_VALID;
    endproperty
    property p_step;
        $changed(ERR_COUNT) |-> ERR_COUNT == $past(ERR_COUNT) + 8'h01;
    endproperty
    property p_err;
        RX_DONE && (RX_STATUS.len_err || RX_STATUS.crc_err) && ERR_COUNT != ERR_MAX
            |-> ##[0:2] $changed(ERR_COUNT);
    endproperty
    property p_start;
        RX_DONE |-> ACQ_TRIGGER == (RX_VALID || (RX_STATUS.sync_pulse && PULSE_MODE));
    endproperty
    property p_trig;
        ACQ_TRIGGER |-> RX_DONE;
    endproperty
    property p_marker;
        RX_VALID |-> RX_STATUS.regular == (RX_FRAME.marker != MARKER_OTHER);
    endproperty
    property p_freeze;
        FRAME_ACTIVE |-> !TX_READY;
    endproperty

    a_release: assert property (p_release) else $error("output enable differs from select");
    a_close: assert property (p_close) else $error("no single result after frame close");
    a_count: assert property (p_count) else $error("wrong bit count not flagged");
    a_good: assert property (p_good) else $error("good frame with bad length or check");
    a_keep: assert property (p_keep) else $error("stored frame changed without good frame");
    a_step: assert property (p_step) else $error("error count did not step by one");
    a_err: assert property (p_err) else $error("discarded frame not counted");
    a_start: assert property (p_start) else $error("trigger does not match outcome");
    a_trig: assert property (p_trig) else $error("trigger outside result cycle");
    a_marker: assert property (p_marker) else $error("regular flag disagrees with tag");
    a_freeze: assert property (p_freeze) else $error("buffer loadable during frame");
endmodule

bind sfs_slave_top sfs_slave_checker #(.FRAME_PERIOD_CYC_P(FRAME_PERIOD_CYC_P)) chk_u (
    .CLK(CLK), .SYS_RST(SYS_RST), .SS_N(SS_N), .MISO_OE_N(MISO_OE_N),
    .PULSE_MODE(PULSE_MODE), .TX_READY(TX_READY), .RX_FRAME(RX_FRAME),
    .RX_VALID(RX_VALID), .RX_DONE(RX_DONE), .RX_STATUS(RX_STATUS), .RX_BITS(RX_BITS),
    .ERR_COUNT(ERR_COUNT), .ACQ_TRIGGER(ACQ_TRIGGER), .FRAME_ACTIVE(FRAME_ACTIVE)
);

//--- verif/sfs_master_model.sv
// serial master model: select, clock and data towards one slave
// assumes the bench calls one task at a time; clock period 125 ns
`timescale 1ns/100ps
module sfs_master_model (
    output logic      SCLK,       // serial clock, idle low
    output logic      SS_N,       // private select of this slave
    output logic      MOSI,       // data to the slave
    input  wire logic MISO_O,     // slave data
    input  wire logic MISO_OE_N   // slave enable, low
);
    logic miso_last;
    logic miso_line;
    // a released line shows the inverse of its last value
    assign miso_line = MISO_OE_N ? ~miso_last : MISO_O;
    always @(MISO_O or MISO_OE_N) if (!MISO_OE_N) miso_last = MISO_O;
    initial begin
        SCLK = 0;
        SS_N = 0;
        MOSI = 0;
        miso_last = 0;
        // a first rising select clears the slave's link state
        #5 SS_N = 1;
    end
    task automatic xfer(input logic [63:0] tx, input int n, input int lead,
                        output logic [63:0] rx);
        int i;
        rx = '0;
        // link edges stay clear of the system clock edges
        #7;
        SS_N = 0;
        #(lead);
        for (i = 0; i < n; i++) begin
            SCLK = 1;
            MOSI = (i < 64) ? tx[63-i] : ~MOSI;
            #62.5;
            SCLK = 0;
            rx = {rx[62:0], miso_line};
            #62.5;
        end
        #250;
        SS_N = 1;
        MOSI = ~MOSI;
    endtask
    task automatic sync_pulse;
        #7;
        SS_N = 0;
        #1000;
        SS_N = 1;
    endtask
endmodule

//--- verif/tb.sv
// self-checking bench of the serial frame slave driven by a master model
// assumes the checker binds itself from its own file
`timescale 1ns/100ps
module tb;
    import sfs_pkg::*;
    typedef struct packed {
        sfs_stat_s   stat;
        sfs_stat_s   mask;
        logic [6:0]  bits;
        logic        acq;
        logic [63:0] frame;
    } sfs_exp_s;
    logic        CLK, SYS_RST, SCLK, SS_N, MOSI, MISO_O, MISO_OE_N, PULSE_MODE, TX_LOAD, CE;
    logic        TX_READY, RX_VALID, RX_DONE, ACQ_TRIGGER, FRAME_ACTIVE;
    logic [55:0] TX_PAYLOAD, body;
    sfs_frame_s  RX_FRAME;
    sfs_stat_s   RX_STATUS;
    logic [6:0]  RX_BITS;
    logic [7:0]  ERR_COUNT;
    logic [63:0] rx_got;
    sfs_exp_s    exp_q[$];
    int          mismatches, checks, cyc, errs, m;

    sfs_slave_top #(.FRAME_PERIOD_CYC_P(400)) dut_u (
        .CLK(CLK), .SYS_RST(SYS_RST), .CE(CE), .SCLK(SCLK), .SS_N(SS_N), .MOSI(MOSI),
        .MISO_O(MISO_O), .MISO_OE_N(MISO_OE_N), .PULSE_MODE(PULSE_MODE),
        .TX_PAYLOAD(TX_PAYLOAD), .TX_LOAD(TX_LOAD), .TX_READY(TX_READY), .RX_FRAME(RX_FRAME),
        .RX_VALID(RX_VALID), .RX_DONE(RX_DONE), .RX_STATUS(RX_STATUS), .RX_BITS(RX_BITS),
        .ERR_COUNT(ERR_COUNT), .ACQ_TRIGGER(ACQ_TRIGGER), .FRAME_ACTIVE(FRAME_ACTIVE)
    );
    sfs_master_model mst_u (.SCLK(SCLK), .SS_N(SS_N), .MOSI(MOSI), .MISO_O(MISO_O),
                            .MISO_OE_N(MISO_OE_N));

    initial begin
        CLK = 0;
        forever #25 CLK = ~CLK;
    end

    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] want);
        checks++;
        if (seen !== want) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, want, seen);
        end
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    function automatic logic [7:0] crc8(input logic [55:0] d);
        logic [7:0] c;
        logic       fb;
        c = CRC_INIT;
        for (int i = 55; i >= 0; i--) begin
            fb = c[7] ^ d[i];
            c = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
        end
        return ~c;
    endfunction
    task automatic wait_cyc(input int k);
        repeat (k) @(posedge CLK);
        @(negedge CLK);
    endtask
    // loads a fresh answer, then exchanges one frame of n bits
    task automatic frame(input logic [55:0] b, input logic [7:0] flip, input int n,
                         input logic fast);
        logic [55:0] pl;
        logic [63:0] mo;
        sfs_exp_s    e;
        pl = 56'({$urandom, $urandom});
        chk("TX_READY", TX_READY, 1'b1);
        @(posedge CLK);
        TX_PAYLOAD <= pl;
        TX_LOAD <= 1'b1;
        @(posedge CLK);
        TX_LOAD <= 1'b0;
        mo = {b, crc8(b) ^ flip};
        e = '0;
        e.mask = (n == 64) ? 5'h1F : 5'h17;
        e.stat.len_err = (n != 64);
        e.stat.crc_err = (n == 64) && (flip != 8'h00);
        e.acq = !e.stat.len_err && !e.stat.crc_err;
        e.stat.regular = e.acq && (b[7:6] != MARKER_OTHER);
        e.stat.rate_fast = fast && e.acq;
        e.bits = 7'(n);
        e.frame = mo;
        exp_q.push_back(e);
        mst_u.xfer(mo, n, fast ? 250 : 1000, rx_got);
        if (n == 64) chk("MISO", rx_got, {pl, crc8(pl)});
    endtask
    task automatic sync(input logic pm);
        sfs_exp_s e;
        @(posedge CLK);
        PULSE_MODE <= pm;
        e = '0;
        e.mask = pm ? 5'h1F : 5'h15;
        e.stat.sync_pulse = 1'b1;
        e.stat.len_err = !pm;
        e.acq = pm;
        exp_q.push_back(e);
        wait_cyc(4);
        mst_u.sync_pulse;
        wait_cyc(450);
    endtask

    initial begin
        sfs_exp_s e;
        forever begin
            @(negedge CLK);
            if (RX_DONE === 1'b1) begin
                if (exp_q.size() == 0) chk("RX_DONE", 1'b1, 1'b0);
                else begin
                    e = exp_q.pop_front();
                    chk("RX_STATUS", RX_STATUS & e.mask, e.stat & e.mask);
                    chk("RX_BITS", RX_BITS, e.bits);
                    chk("RX_VALID", RX_VALID, e.acq && !e.stat.sync_pulse);
                    chk("ACQ_TRIGGER", ACQ_TRIGGER, e.acq);
                    if (e.acq && !e.stat.sync_pulse) chk("RX_FRAME", RX_FRAME, e.frame);
                    errs += (e.stat.len_err || e.stat.crc_err);
                    repeat (2) @(negedge CLK);
                    chk("ERR_COUNT", ERR_COUNT, errs);
                end
            end
        end
    end

    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            stop_test;
        end
    end

    initial begin
        SYS_RST = 1;
        CE = 1;
        PULSE_MODE = 0;
        TX_LOAD = 0;
        TX_PAYLOAD = '0;
        mismatches = 0;
        checks = 0;
        cyc = 0;
        errs = 0;
        void'($urandom(86));
        repeat (8) @(posedge CLK);
        SYS_RST <= 1'b0;
        chk("CRC", crc8(56'hC1FF16FFD4FF86), 8'h23);
        wait_cyc(450);
        frame(56'hC1FF16FFD4FF86, 8'h00, 64, 1'b0);
        for (m = 0; m < 4; m++) begin
            body = 56'({$urandom, $urandom});
            body[7:6] = 2'(m);
            wait_cyc(m == 2 ? 10 : 450);
            frame(body, 8'h00, 64, m == 2);
        end
        wait_cyc(450);
        frame(56'({$urandom, $urandom}), 8'(1 + $urandom_range(0, 254)), 64, 1'b0);
        for (m = 63; m < 66; m += 2) begin
            wait_cyc(450);
            frame(56'({$urandom, $urandom}), 8'h00, m, 1'b0);
        end
        wait_cyc(450);
        sync(1'b1);
        sync(1'b0);
        // a pulse while the system side is frozen must leave no result
        @(posedge CLK);
        CE <= 1'b0;
        mst_u.sync_pulse;
        @(posedge CLK);
        CE <= 1'b1;
        wait_cyc(450);
        frame(56'({$urandom, $urandom}), 8'h00, 64, 1'b0);
        wait_cyc(100);
        chk("PENDING", exp_q.size(), 0);
        stop_test;
    end
endmodule
